// ===== eoc_pkg.sv
// constants, types and helpers of the encoder output configuration block
// assumes a 125 MHz clk and classic wishbone register access
`default_nettype none

package eoc_pkg;

    // ------------------------------------------------------------
    // register map (byte addresses on a 32-bit wishbone)
    // ------------------------------------------------------------
    localparam int unsigned ADR_W    = 4;
    localparam logic [3:0]  REG_CTRL = 4'h0;  // direction, width, level, speed
    localparam logic [3:0]  REG_RES  = 4'h4;  // pulses per revolution
    localparam logic [3:0]  REG_IDX  = 4'h8;  // stored index angle
    localparam logic [3:0]  REG_STAT = 4'hC;  // live state, read only

    // ------------------------------------------------------------
    // control field positions
    // ------------------------------------------------------------
    localparam int unsigned CTRL_DIR  = 0;    // 1: count up for ccw
    localparam int unsigned CTRL_WIDE = 1;    // 1: half-cycle index
    localparam int unsigned CTRL_LVL  = 2;    // 1: fixed logic level
    localparam int unsigned CTRL_SPD  = 4;    // two-bit speed option
    localparam int unsigned CTRL_SET  = 8;    // write 1: capture index
    localparam int unsigned STAT_REV  = 0;    // effective reversal
    localparam int unsigned STAT_PIN  = 1;    // filtered direction pin
    localparam int unsigned STAT_SPD  = 2;    // speed option in force

    // ------------------------------------------------------------
    // widths and limits
    // ------------------------------------------------------------
    localparam int unsigned ANGLE_W = 18;     // shaft angle, one rev
    localparam int unsigned RES_W   = 17;     // resolution field
    localparam int unsigned PROD_W  = ANGLE_W + RES_W;
    localparam int unsigned PIN_W   = 3;      // dir, index set, button
    localparam logic [RES_W-1:0] RES_MIN = 17'h00001;
    localparam logic [RES_W-1:0] RES_MAX = 17'h10000;
    localparam logic [RES_W-1:0] RES_RST = 17'h00400;

    // ------------------------------------------------------------
    // speed options and counting-frequency ceiling
    // ------------------------------------------------------------
    typedef enum logic [1:0] {SPD_LOW, SPD_MID, SPD_HIGH} eoc_speed_e;
    localparam logic [31:0] RPM_LOW   = 32'd2250;
    localparam logic [31:0] RPM_MID   = 32'd4500;
    localparam logic [31:0] RPM_HIGH  = 32'd9000;
    localparam logic [31:0] FMAX_KHZ  = 32'd500;
    localparam logic [31:0] KHZ_MIN   = 32'd60000;  // rpm*ppr per khz
    localparam logic [31:0] FMAX_PROD = FMAX_KHZ * KHZ_MIN;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic dir_ccw;
        logic idx_wide;
        logic lvl_fixed;
        eoc_speed_e speed;
    } eoc_ctrl_s;

    typedef struct packed {
        logic a;
        logic b;
        logic z;
    } eoc_quad_s;

    localparam eoc_ctrl_s CTRL_RST = '{1'b0, 1'b0, 1'b0, SPD_HIGH};

    // rpm of a speed option
    function automatic logic [31:0] rpm_of(input eoc_speed_e s);
        case (s)
            SPD_LOW: rpm_of = RPM_LOW;
            SPD_MID: rpm_of = RPM_MID;
            default: rpm_of = RPM_HIGH;
        endcase
    endfunction

    // option usable when its counting frequency stays at or under the ceiling
    function automatic logic spd_ok(input eoc_speed_e s,
                                    input logic [RES_W-1:0] r);
        logic [48:0] p;
        p = rpm_of(s) * r;
        spd_ok = (p <= {17'h00000, FMAX_PROD});
    endfunction

endpackage

`default_nettype wire

// ===== eoc_pin_sync.sv
// three-flop filter for the asynchronous pins of the block
// assumes pins may change at any time; output moves when ff2 and ff3 agree
`default_nettype none
`timescale 1ns/10ps

module eoc_pin_sync
    import eoc_pkg::*;
(
    // clock and reset
    input  wire logic              clk,
    input  wire logic              srst,
    // raw pins and filtered levels
    input  wire logic [PIN_W-1:0]  pin_raw,
    output logic      [PIN_W-1:0]  pin_level
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [PIN_W-1:0] ff1;     // metastable stage, read by ff2 only
        logic [PIN_W-1:0] ff2;
        logic [PIN_W-1:0] ff3;
        logic [PIN_W-1:0] level;   // accepted level
    } eoc_sync_s;

    eoc_sync_s st_q;
    eoc_sync_s st_d;
    logic [PIN_W-1:0] agree;       // ff2 and ff3 match

    // next state: a change counts once two stages agree
    always_comb
    begin
        st_d     = st_q;
        agree    = ~(st_q.ff2 ^ st_q.ff3);
        st_d.ff1 = pin_raw;
        st_d.ff2 = st_q.ff1;
        st_d.ff3 = st_q.ff2;
        st_d.level = (agree & st_q.ff3) | (~agree & st_q.level);
    end

    // registers
    always_ff @(posedge clk)
    begin
        if (srst)
            st_q <= '0;
        else
            st_q <= st_d;
    end

    assign pin_level = st_q.level;

endmodule // eoc_pin_sync

`default_nettype wire

// ===== eoc_quad_gen.sv
// quadrature and index shaping from shaft angle and resolution
// assumes the shaft angle comes from sensor logic on the same clock
`default_nettype none
`timescale 1ns/10ps

module eoc_quad_gen
    import eoc_pkg::*;
(
    // clock and reset
    input  wire logic                clk,
    input  wire logic                srst,
    // settings
    input  wire logic [ANGLE_W-1:0]  shaft_angle,
    input  wire logic [RES_W-1:0]    res,
    input  wire logic [ANGLE_W-1:0]  idx_pos,
    input  wire logic                idx_wide,
    input  wire logic                reverse,
    // shaped channels, true and inverted
    output eoc_pkg::eoc_quad_s       quad_q,
    output eoc_pkg::eoc_quad_s       quad_n_q
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        eoc_quad_s q;
        eoc_quad_s n;
    } eoc_qg_s;

    eoc_qg_s st_q;
    eoc_qg_s st_d;
    logic [PROD_W-1:0] pos_prod;   // angle scaled by pulses per rev
    logic [PROD_W-1:0] idx_prod;   // index angle scaled the same way
    logic [1:0]        phase;      // quarter of the electrical cycle
    logic              ch_a;
    logic              ch_b;
    logic              in_cycle;   // inside the index cycle
    logic              gate;

    // shaping: phase 1,2 give a; 2,3 give b, so a leads b going cw
    always_comb
    begin
        st_d     = st_q;
        pos_prod = shaft_angle * res;
        idx_prod = idx_pos * res;
        phase    = pos_prod[ANGLE_W-1 -: 2];
        ch_a     = phase[0] ^ phase[1];
        ch_b     = phase[1];
        in_cycle = pos_prod[PROD_W-1:ANGLE_W] == idx_prod[PROD_W-1:ANGLE_W];
        st_d.q.a = reverse ? ch_b : ch_a;
        st_d.q.b = reverse ? ch_a : ch_b;
        // narrow: where a and b are both high; wide: wherever a is high
        gate     = idx_wide ? st_d.q.a : (ch_a & ch_b);
        st_d.q.z = in_cycle & gate;
        st_d.n   = ~st_d.q;
    end

    // registers
    always_ff @(posedge clk)
    begin
        if (srst)
            st_q <= '{3'h0, 3'h7};
        else
            st_q <= st_d;
    end

    assign quad_q   = st_q.q;
    assign quad_n_q = st_q.n;

endmodule // eoc_quad_gen

`default_nettype wire

// ===== eoc_encoder_output_config.sv
// top of the encoder output configuration block: wishbone registers,
// direction resolution, index capture, speed limiting and output shaping
// assumes a same-clock shaft angle and asynchronous pins and button
//
// Local design decisions: the placing of the registers and register access over Wishbone.
`default_nettype none
`timescale 1ns/10ps

module eoc_encoder_output_config
    import eoc_pkg::*;
(
    // clock and reset
    input  wire logic                 clk,
    input  wire logic                 srst,
    // wishbone slave
    input  wire logic [ADR_W-1:0]     wb_adr_i,
    input  wire logic [31:0]          wb_dat_i,
    input  wire logic [3:0]           wb_sel_i,
    input  wire logic                 wb_we_i,
    input  wire logic                 wb_cyc_i,
    input  wire logic                 wb_stb_i,
    output logic [31:0]               wb_dat_o,
    output logic                      wb_ack_o,
    // shaft sensor
    input  wire logic [ANGLE_W-1:0]   shaft_angle,
    // asynchronous pins
    input  wire logic                 dir_pin,
    input  wire logic                 idx_set_pin,
    input  wire logic                 idx_button,
    // encoder outputs
    output eoc_pkg::eoc_quad_s        quadrature_and_index_outputs,
    output eoc_pkg::eoc_quad_s        inverted_quadrature_and_index_outputs,
    output logic                      out_level_fixed,
    output eoc_pkg::eoc_speed_e       speed_sel,
    output logic                      count_reverse
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic              ack;        // one-cycle wishbone answer
        logic [31:0]       dat;        // registered read data
        eoc_ctrl_s         ctrl;       // software settings
        logic [RES_W-1:0]  res;        // clamped pulses per rev
        logic [ANGLE_W-1:0] idx_pos;   // captured index angle
        logic [1:0]        req_prev;   // last pin and button levels
        logic              reverse;    // effective count reversal
        eoc_speed_e        speed_eff;  // option actually in force
    } eoc_top_s;

    eoc_top_s st_q;
    eoc_top_s st_d;

    // filtered pins: [0] direction, [1] index pin, [2] button
    logic [PIN_W-1:0] pin_lvl;

    // helpers
    logic        req;              // wishbone access in this cycle
    logic        wr;               // write taken this cycle
    logic [31:0] ctrl_word;        // control register as read
    logic [31:0] stat_word;        // status register as read
    logic [31:0] merged;           // write data merged by byte lanes
    logic [31:0] cur_word;         // addressed register before write
    logic        set_cmd;          // software index capture
    logic        set_hw;           // pin or button index capture
    logic [1:0]  req_now;          // current pin and button levels

    // ------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------

    // control register as seen by software
    function automatic logic [31:0] ctrl_to_word(input eoc_ctrl_s c);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[CTRL_DIR]  = c.dir_ccw;
        w[CTRL_WIDE] = c.idx_wide;
        w[CTRL_LVL]  = c.lvl_fixed;
        w[CTRL_SPD +: 2] = c.speed;
        ctrl_to_word = w;
    endfunction

    // byte-lane merge of write data over the old register value
    function automatic logic [31:0] lane_merge(input logic [31:0] old_w,
                                               input logic [31:0] new_w,
                                               input logic [3:0]  sel);
        logic [31:0] m;
        m = old_w;
        for (int i = 0; i < 4; i++)
        begin
            if (sel[i])
                m[8*i +: 8] = new_w[8*i +: 8];
        end
        lane_merge = m;
    endfunction

    // clamp a resolution request into range
    function automatic logic [RES_W-1:0] res_clamp(input logic [31:0] w);
        if (w < {15'h0000, RES_MIN})
            res_clamp = RES_MIN;
        else if (w > {15'h0000, RES_MAX})
            res_clamp = RES_MAX;
        else
            res_clamp = w[RES_W-1:0];
    endfunction

    // largest usable option not above the requested one
    function automatic eoc_speed_e spd_limit(input eoc_speed_e s,
                                             input logic [RES_W-1:0] r);
        eoc_speed_e e;
        e = s;
        if (e == SPD_HIGH && !spd_ok(SPD_HIGH, r))
            e = SPD_MID;
        if (e == SPD_MID && !spd_ok(SPD_MID, r))
            e = SPD_LOW;
        // the lowest option stays usable: a hard floor keeps the
        // outputs alive even if the ceiling is set absurdly low
        spd_limit = e;
    endfunction

    // ------------------------------------------------------------
    // submodules
    // ------------------------------------------------------------

    // pins and the button are not on clk, so they pass the filter
    eoc_pin_sync u_sync
    (
        .clk       (clk),
        .srst      (srst),
        .pin_raw   ({idx_button, idx_set_pin, dir_pin}),
        .pin_level (pin_lvl)
    );

    // channel shaping runs from the registered settings only
    eoc_quad_gen u_quad
    (
        .clk         (clk),
        .srst        (srst),
        .shaft_angle (shaft_angle),
        .res         (st_q.res),
        .idx_pos     (st_q.idx_pos),
        .idx_wide    (st_q.ctrl.idx_wide),
        .reverse     (st_q.reverse),
        .quad_q      (quadrature_and_index_outputs),
        .quad_n_q    (inverted_quadrature_and_index_outputs)
    );

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------

    // bus answer, register writes, index capture, derived settings
    always_comb
    begin
        st_d = st_q;

        // read views of the registers
        ctrl_word = ctrl_to_word(st_q.ctrl);
        stat_word = 32'h0000_0000;
        stat_word[STAT_REV] = st_q.reverse;
        stat_word[STAT_PIN] = pin_lvl[0];
        stat_word[STAT_SPD +: 2] = st_q.speed_eff;

        // ack lasts one cycle; cyc/stb still high after it is taken as the next request
        req = wb_cyc_i & wb_stb_i & ~st_q.ack;
        wr  = req & wb_we_i;
        st_d.ack = req;

        // addressed register, unmapped reads as zero
        case (wb_adr_i)
            REG_CTRL: cur_word = ctrl_word;
            REG_RES:  cur_word = {15'h0000, st_q.res};
            REG_IDX:  cur_word = {14'h0000, st_q.idx_pos};
            REG_STAT: cur_word = stat_word;
            default:  cur_word = 32'h0000_0000;
        endcase
        merged = lane_merge(cur_word, wb_dat_i, wb_sel_i);

        // read data registered with the answer
        if (req)
            st_d.dat = cur_word;
        else
            st_d.dat = 32'h0000_0000;

        // writes; status, index and unmapped are read only
        set_cmd = 1'b0;
        if (wr)
        begin
            case (wb_adr_i)
                REG_CTRL:
                begin
                    st_d.ctrl.dir_ccw   = merged[CTRL_DIR];
                    st_d.ctrl.idx_wide  = merged[CTRL_WIDE];
                    st_d.ctrl.lvl_fixed = merged[CTRL_LVL];
                    // code three is not an option; keep the old one
                    if (merged[CTRL_SPD +: 2] != 2'h3)
                        st_d.ctrl.speed =
                            eoc_speed_e'(merged[CTRL_SPD +: 2]);
                    set_cmd = merged[CTRL_SET] & wb_sel_i[1];
                end
                REG_RES:
                    st_d.res = res_clamp(merged);
                default:
                begin
                    // ignored write, answered normally
                end
            endcase
        end

        // rising edges of the filtered index pin and button
        req_now = pin_lvl[2:1];
        st_d.req_prev = req_now;
        set_hw = |(req_now & ~st_q.req_prev);

        // capture the angle as it stands; a moving shaft gives a
        // smeared position, so the operator stops the axis first
        if (set_cmd || set_hw)
            st_d.idx_pos = shaft_angle;

        // pin low keeps the stored sense, pin high inverts it
        st_d.reverse = st_d.ctrl.dir_ccw ^ pin_lvl[0];

        // speed option follows the latest resolution
        st_d.speed_eff = spd_limit(st_d.ctrl.speed, st_d.res);
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------

    // every setting returns to its default on reset
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            st_q.ack       <= 1'b0;
            st_q.dat       <= 32'h0000_0000;
            st_q.ctrl      <= CTRL_RST;
            st_q.res       <= RES_RST;
            st_q.idx_pos   <= '0;
            st_q.req_prev  <= 2'h0;
            st_q.reverse   <= 1'b0;
            st_q.speed_eff <= SPD_HIGH;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    // ------------------------------------------------------------
    // outputs, each straight from a flop
    // ------------------------------------------------------------
    assign wb_ack_o        = st_q.ack;
    assign wb_dat_o        = st_q.dat;
    assign out_level_fixed = st_q.ctrl.lvl_fixed;
    assign speed_sel       = st_q.speed_eff;
    assign count_reverse   = st_q.reverse;

endmodule // eoc_encoder_output_config

`default_nettype wire

// ===== eoc_cnt_model.sv
// far-side counter model: 4x quadrature decode and index statistics
// assumes the true channels are registered on the same clk
`timescale 1ns/10ps
`default_nettype none
module eoc_cnt_model
    import eoc_pkg::*;
(
    // clock and received channels
    input  wire logic               clk,
    input  wire eoc_pkg::eoc_quad_s rx,
    // position, index rises, index high cycles
    output var int                  pos,
    output var int                  idx_rise,
    output var int                  idx_len
);
    logic [1:0] g;          // phase index of the pair
    logic [1:0] g_q = 2'h0; // phase index one edge ago
    logic       z_q = 1'b0; // index level one edge ago
    // 00,10,11,01 counts up, so a leading b is up
    assign g = {rx.b, rx.a ^ rx.b};
    // a two-phase jump is ambiguous and dropped, as real counters do
    always_ff @(posedge clk)
    begin
        g_q <= g;
        z_q <= rx.z;
        if (g - g_q == 2'h1)
            pos <= pos + 1;
        else if (g_q - g == 2'h1)
            pos <= pos - 1;
        if (rx.z && !z_q)
            idx_rise <= idx_rise + 1;
        if (rx.z)
            idx_len <= idx_len + 1;
    end
endmodule // eoc_cnt_model
`default_nettype wire

// ===== eoc_encoder_output_config_sva.sv
// port assertions of the encoder output configuration top
// assumes one clk domain and synchronous active-high srst
`timescale 1ns/10ps
`default_nettype none
module eoc_output_sva
    import eoc_pkg::*;
(
    // clock, reset and wishbone
    input  wire logic                clk,
    input  wire logic                srst,
    input  wire logic [ADR_W-1:0]    wb_adr_i,
    input  wire logic [31:0]         wb_dat_i,
    input  wire logic [3:0]          wb_sel_i,
    input  wire logic                wb_we_i,
    input  wire logic                wb_cyc_i,
    input  wire logic                wb_stb_i,
    input  wire logic                wb_ack_o,
    // pin and outputs
    input  wire logic                dir_pin,
    input  wire eoc_pkg::eoc_quad_s  quadrature_and_index_outputs,
    input  wire eoc_pkg::eoc_quad_s  inverted_quadrature_and_index_outputs,
    input  wire logic                out_level_fixed,
    input  wire eoc_pkg::eoc_speed_e speed_sel,
    input  wire logic                count_reverse
);
    logic       wr_c;   // control write seen at its ack
    logic [2:0] sh;     // shadow level, width, direction
    logic [1:0] spd_s;  // shadow speed request
    logic       pin_q;  // pin one edge ago
    logic [3:0] calm;   // edges since pin or control moved
    eoc_quad_s  q;      // alias of the true channels
    assign q = quadrature_and_index_outputs;
    assign wr_c = wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i
                  && wb_adr_i == REG_CTRL && wb_sel_i[0];
    // shadow taken one edge late, so checks wait a little longer
    always_ff @(posedge clk)
    begin
        pin_q <= dir_pin;
        if (srst)
            {sh, spd_s, calm} <= 9'h020;
        else
        begin
            if (wr_c)
                sh <= wb_dat_i[2:0];
            // code 3 is dropped by the block
            if (wr_c && wb_dat_i[5:4] != 2'h3)
                spd_s <= wb_dat_i[5:4];
            calm <= (wr_c || dir_pin != pin_q) ? 4'h0
                  : calm + {3'h0, calm != 4'hF};
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
    sequence s_ans; wb_ack_o ##1 !wb_ack_o; endsequence
    property p_ack; s_req |=> s_ans; endproperty
    a_ack: assert property (p_ack) else $error("ack not one pulse");
    property p_inv; inverted_quadrature_and_index_outputs == ~q; endproperty
    a_inv: assert property (p_inv) else $error("inverted pair wrong");
    property p_narrow; (!sh[1])[*4] ##0 q.z |-> q.a && q.b; endproperty
    a_narrow: assert property (p_narrow) else $error("narrow gate");
    property p_wide; sh[1][*4] ##0 q.z |-> q.a; endproperty
    a_wide: assert property (p_wide) else $error("wide gate");
    property p_lvl; wr_c |=> ##1 out_level_fixed == sh[2]; endproperty
    a_lvl: assert property (p_lvl) else $error("level bit");
    property p_spd; wr_c |=> ##1 speed_sel <= spd_s && speed_sel != 2'h3;
    endproperty
    a_spd: assert property (p_spd) else $error("speed above request");
    // calm is sampled before it clears, so the moving edge is left out
    property p_rev; calm > 4'h6 && !wr_c && dir_pin == pin_q
        |-> count_reverse == (sh[0] ^ dir_pin); endproperty
    a_rev: assert property (p_rev) else $error("reverse not xor");
    property p_rst; $fell(srst) |-> !out_level_fixed && !count_reverse
        && speed_sel == SPD_HIGH && q == 3'h0; endproperty
    a_rst: assert property (p_rst) else $error("reset outputs");
endmodule // eoc_output_sva
bind eoc_encoder_output_config eoc_output_sva u_sva (.clk, .srst, .wb_adr_i,
    .wb_dat_i, .wb_sel_i, .wb_we_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
    .dir_pin, .quadrature_and_index_outputs,
    .inverted_quadrature_and_index_outputs, .out_level_fixed, .speed_sel,
    .count_reverse);
`default_nettype wire

// ===== eoc_encoder_output_config_bench.sv
// self-checking bench of the encoder output configuration top
// assumes package, design, checker and counter model compiled first
`timescale 1ns/10ps
`default_nettype none
module eoc_encoder_output_config_bench;
    import eoc_pkg::*;
    logic clk = 1'b0, srst = 1'b1, wb_we_i = 1'b0;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_ack_o;
    logic [ADR_W-1:0] wb_adr_i = '0;
    logic [31:0] wb_dat_i = '0, wb_dat_o, rd;
    logic [3:0] wb_sel_i = '0;
    logic [17:0] shaft_angle = 18'h20000; // start away from index
    logic dir_pin = 1'b0; // low until the direction mix drives it, left high after
    logic idx_set_pin = 1'b0, idx_button = 1'b0;
    eoc_quad_s quadrature_and_index_outputs;
    eoc_quad_s inverted_quadrature_and_index_outputs;
    logic out_level_fixed, count_reverse;
    eoc_speed_e speed_sel;
    int pos, idx_rise, idx_len, p0, i0, l0;
    int n_errors = 0, samples_checked = 0;
    // clamp rows, then speed rows: resolution, request, result
    logic [31:0] rq [4] = '{32'h0, 32'h20000, 32'hFFFFFFFF, 32'h5};
    logic [31:0] re [4] = '{32'h1, 32'h10000, 32'h10000, 32'h5};
    logic [31:0] sr [5] = '{32'h400, 32'hFA0, 32'h10000, 32'hFA0, 32'h400};
    logic [1:0] sq [5] = '{2'h2, 2'h2, 2'h2, 2'h0, 2'h3};
    logic [1:0] se [5] = '{2'h2, 2'h1, 2'h0, 2'h0, 2'h0};
    eoc_encoder_output_config dut (.clk, .srst, .wb_adr_i, .wb_dat_i,
        .wb_sel_i, .wb_we_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o,
        .shaft_angle, .dir_pin, .idx_set_pin, .idx_button,
        .quadrature_and_index_outputs,
        .inverted_quadrature_and_index_outputs, .out_level_fixed,
        .speed_sel, .count_reverse);
    eoc_cnt_model u_cnt (.clk, .rx(quadrature_and_index_outputs), .pos,
        .idx_rise, .idx_len);
    initial
    begin
        forever #4 clk = ~clk;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one classic cycle; waits for ack, read word left in rd
    task automatic xfer(input logic [3:0] a, input logic w,
                        input logic [31:0] d);
        wb_adr_i <= a;
        wb_we_i <= w;
        wb_dat_i <= d;
        wb_sel_i <= 4'hF;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        @(posedge clk);
        // no local limit: a missing ack is left to the watchdog
        while (wb_ack_o !== 1'b1)
        begin
            @(posedge clk);
        end
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        @(posedge clk);
    endtask
    task automatic results();
        $display("errors %0d checks %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial
    begin
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        xfer(REG_CTRL, 1'b0, '0);
        check(rd, 32'h00000020);
        xfer(REG_RES, 1'b0, '0);
        check(rd, 32'h00000400);
        xfer(REG_STAT, 1'b0, '0);
        check(rd, 32'h00000008);
        xfer(4'h2, 1'b0, '0);
        check(rd, 32'h00000000);
        xfer(REG_CTRL, 1'b1, 32'h00000024);
        @(posedge clk);
        check({31'h0, out_level_fixed}, 32'h00000001);
        foreach (rq[i])
        begin
            xfer(REG_RES, 1'b1, rq[i]);
            xfer(REG_RES, 1'b0, '0);
            check(rd, re[i]);
        end
        // speed rows, as an operator would pick them
        foreach (sr[i])
        begin
            xfer(REG_RES, 1'b1, sr[i]);
            xfer(REG_CTRL, 1'b1, {26'h0, sq[i], 4'h0});
            @(posedge clk);
            check({30'h0, speed_sel}, {30'h0, se[i]});
        end
        // every direction, pin and width mix over one full turn
        xfer(REG_RES, 1'b1, 32'h00000004);
        for (int k = 0; k < 8; k++)
        begin
            dir_pin <= k[0];
            xfer(REG_CTRL, 1'b1, {26'h0, 2'h2, 2'h0, k[2], k[1]});
            repeat (8) @(posedge clk);
            p0 = pos;
            i0 = idx_rise;
            l0 = idx_len;
            repeat (1024)
            begin
                shaft_angle <= shaft_angle + 18'h00100;
                @(posedge clk);
            end
            repeat (6) @(posedge clk);
            check(pos - p0, (k[1] ^ k[0]) ? -16 : 16);
            check(idx_rise - i0, 1);
            check(idx_len - l0, k[2] ? 128 : 64);
            check({31'h0, count_reverse}, {31'h0, k[1] ^ k[0]});
            xfer(REG_STAT, 1'b0, '0);
            check(rd & 32'h3, {30'h0, k[0], k[1] ^ k[0]});
        end
        // index set by command, pin and button; re-read after
        for (int s = 0; s < 3; s++)
        begin
            shaft_angle <= 18'h11111 * 18'(s + 1);
            repeat (2) @(posedge clk);
            if (s == 0)
                xfer(REG_CTRL, 1'b1, 32'h00000120);
            idx_set_pin <= (s == 1);
            idx_button <= (s == 2);
            repeat (8) @(posedge clk);
            idx_set_pin <= 1'b0;
            idx_button <= 1'b0;
            repeat (8) @(posedge clk);
            xfer(REG_IDX, 1'b0, '0);
            check(rd, {14'h0, 18'h11111 * 18'(s + 1)});
        end
        xfer(REG_IDX, 1'b1, '0);
        xfer(REG_IDX, 1'b0, '0);
        check(rd, 32'h00033333);
        results();
    end
    initial
    begin
        repeat (40000) @(posedge clk);
        n_errors++;
        results();
    end
endmodule // eoc_encoder_output_config_bench
`default_nettype wire
